// ---- logic/gpfm_pkg.sv ----
// gpfm_pkg: register map, field layout and function codes of the pin mux
// assumes a 32-bit Avalon-MM slave port with byte addresses
package gpfm_pkg;

	// =====================================================
	// register indices, byte address is four times the index
	localparam logic [5:0] GPFM_IDX_PIN_ONE = 6'h0C;
	localparam logic [5:0] GPFM_IDX_PIN_TWO = 6'h0D;
	localparam logic [5:0] GPFM_IDX_IRQ_STATUS = 6'h10;
	localparam logic [5:0] GPFM_IDX_IRQ_MASK = 6'h11;
	localparam logic [5:0] GPFM_IDX_DIRECT_IO = 6'h12;

	// =====================================================
	// field positions and reset values
	localparam int GPFM_SEL_MSB = 4;
	localparam int GPFM_PUP_BIT = 5;
	localparam int GPFM_DRV_MSB = 7;
	localparam int GPFM_DRV_LSB = 6;
	localparam logic [7:0] GPFM_PIN_ONE_RST = 8'h00;
	localparam logic [7:0] GPFM_PIN_TWO_RST = 8'h00;
	localparam int GPFM_ST_EXT = 0;
	localparam int GPFM_ST_RETX = 1;
	localparam int GPFM_ST_RSVD = 2;
	localparam logic [2:0] GPFM_MASK_RST = 3'h0;
	localparam int GPFM_DIO_OUT_BIT = 0;
	localparam int GPFM_DIO_IN_BIT = 1;
	localparam logic GPFM_DIO_OUT_RST = 1'b0;

	// =====================================================
	// function select codes
	localparam logic [4:0] GPFM_FN_NPOR = 5'h00;
	localparam logic [4:0] GPFM_FN_WUT = 5'h01;
	localparam logic [4:0] GPFM_FN_LOWBAT = 5'h02;
	localparam logic [4:0] GPFM_FN_DIN = 5'h03;
	localparam logic [4:0] GPFM_FN_XFALL = 5'h04;
	localparam logic [4:0] GPFM_FN_XRISE = 5'h05;
	localparam logic [4:0] GPFM_FN_XCHG = 5'h06;
	localparam logic [4:0] GPFM_FN_ADC = 5'h07;
	localparam logic [4:0] GPFM_FN_TST_LO = 5'h08;
	localparam logic [4:0] GPFM_FN_DOUT = 5'h0A;
	localparam logic [4:0] GPFM_FN_TST_HI = 5'h0D;
	localparam logic [4:0] GPFM_FN_VREF = 5'h0E;
	localparam logic [4:0] GPFM_FN_BITCLK = 5'h0F;
	localparam logic [4:0] GPFM_FN_TXDATA = 5'h10;
	localparam logic [4:0] GPFM_FN_RETX = 5'h11;
	localparam logic [4:0] GPFM_FN_TXSTATE = 5'h12;
	localparam logic [4:0] GPFM_FN_TXAFULL = 5'h13;
	localparam logic [4:0] GPFM_FN_RXDATA = 5'h14;
	localparam logic [4:0] GPFM_FN_RXSTATE = 5'h15;
	localparam logic [4:0] GPFM_FN_RXAFULL = 5'h16;
	localparam logic [4:0] GPFM_FN_ANT1 = 5'h17;
	localparam logic [4:0] GPFM_FN_ANT2 = 5'h18;
	localparam logic [4:0] GPFM_FN_PRE_OK = 5'h19;
	localparam logic [4:0] GPFM_FN_PRE_BAD = 5'h1A;
	localparam logic [4:0] GPFM_FN_SYNC = 5'h1B;
	localparam logic [4:0] GPFM_FN_CCA = 5'h1C;
	localparam logic [4:0] GPFM_FN_VDD = 5'h1D;

endpackage

// ---- logic/gpfm_pin_mux.sv ----
// gpfm_pin_mux: function mux and pad control of general pin one, config of pin two
// assumes one 50 MHz clock, pin input synchronous, Avalon-MM master on the bus side
//
// Overview of operation
// - pull-up on only when its enable is set and pin is a digital input
// - five-bit function selector sits in bits 4:0 of the pin config register
// - two-bit drive strength sits in bits 7:6 of the pin config register
// - code 00000 drives the inverted power-on reset indication
// - code 00001 drives high once the wake-up timer has expired
// - code 00010 drives high while battery is below the low threshold
// - code 00011 is a direct digital input, 01010 a software-driven output
// - codes 00100, 00101, 00110 interrupt on falling, rising, any edge
// - code 00111 routes the ADC input, 01110 outputs the reference voltage
// - codes 01000 to 01101 except 01010 are reserved test functions, not for normal use
// - 01111 outputs bit clock, 10000 takes transmit data, 10100 outputs receive data
// - code 10001 takes an external retransmission request as input
// - code 10010 shows transmit state, 10101 shows receive state
// - codes 10011 and 10110 show transmit and receive buffer almost full
// - codes 10111 and 11000 drive antenna switches one and two
// - codes 11001 and 11010 show valid and invalid preamble detected
// - code 11011 shows sync word detected
// - code 11100 shows clear channel assessment
//
// Decided for this implementation: the Avalon-MM slave port.
module gpfm_pin_mux
	import gpfm_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	output logic irq_out,
	input wire logic por_active_in,
	input wire logic wake_up_timer_expired_in,
	input wire logic low_battery_in,
	input wire logic bit_clock_in,
	input wire logic rx_data_in,
	input wire logic tx_state_in,
	input wire logic rx_state_in,
	input wire logic tx_almost_full_in,
	input wire logic rx_almost_full_in,
	input wire logic antenna_one_in,
	input wire logic antenna_two_in,
	input wire logic preamble_valid_in,
	input wire logic preamble_invalid_in,
	input wire logic sync_detected_in,
	input wire logic clear_channel_in,
	input wire logic general_pin_one_in,
	output logic general_pin_one_out,
	output logic general_pin_one_oe_out,
	output logic pin_one_pullup_out,
	output logic [1:0] pin_one_drive_strength_out,
	output logic adc_route_out,
	output logic vref_route_out,
	output logic tx_data_out,
	output logic retransmit_request_out,
	output logic [4:0] pin_two_function_select_out,
	output logic pin_two_pullup_enable_out,
	output logic [1:0] pin_two_drive_strength_out
);

	// =====================================================
	// helpers
	function automatic logic gpfm_is_din(input logic [4:0] sel);
		return sel inside {GPFM_FN_DIN, GPFM_FN_XFALL, GPFM_FN_XRISE, GPFM_FN_XCHG,
			GPFM_FN_TXDATA, GPFM_FN_RETX};
	endfunction

	function automatic logic gpfm_is_rsvd(input logic [4:0] sel);
		return sel >= GPFM_FN_TST_LO && sel <= GPFM_FN_TST_HI && sel != GPFM_FN_DOUT;
	endfunction

	// released: inputs, analog routes and the test codes leave the pad undriven
	function automatic logic gpfm_drives(input logic [4:0] sel);
		return !gpfm_is_din(sel) && !gpfm_is_rsvd(sel) && sel != GPFM_FN_ADC
			&& sel != GPFM_FN_VREF;
	endfunction

	// =====================================================
	// bus slave
	logic ack_q;
	logic [7:0] pin_one_q;
	logic [7:0] pin_two_q;
	logic [2:0] status_q;
	logic [2:0] mask_q;
	logic dio_out_q;
	logic [31:0] rdata_q;
	logic [5:0] idx;
	logic req;
	logic wr_commit;
	logic lane0;
	logic [4:0] sel;
	logic [2:0] events;

	assign idx = avs_address_in[7:2];
	assign req = avs_read_in | avs_write_in;
	// every access waits exactly one cycle, read data is ready at the release
	assign avs_waitrequest_out = req & ~ack_q;
	assign wr_commit = avs_write_in & ack_q;
	assign lane0 = avs_byteenable_in[0];
	assign avs_readdata_out = rdata_q;
	assign sel = pin_one_q[GPFM_SEL_MSB:0];

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req & ~ack_q;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			rdata_q <= 32'h0000_0000;
		end else if (avs_read_in && !ack_q) begin
			rdata_q <= 32'h0000_0000;
			if (idx == GPFM_IDX_PIN_ONE) begin
				rdata_q[7:0] <= pin_one_q;
			end else if (idx == GPFM_IDX_PIN_TWO) begin
				rdata_q[7:0] <= pin_two_q;
			end else if (idx == GPFM_IDX_IRQ_STATUS) begin
				rdata_q[2:0] <= status_q;
			end else if (idx == GPFM_IDX_IRQ_MASK) begin
				rdata_q[2:0] <= mask_q;
			end else if (idx == GPFM_IDX_DIRECT_IO) begin
				rdata_q[GPFM_DIO_OUT_BIT] <= dio_out_q;
				rdata_q[GPFM_DIO_IN_BIT] <= general_pin_one_in;
			end
		end
	end

	// =====================================================
	// configuration registers
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			pin_one_q <= GPFM_PIN_ONE_RST;
			pin_two_q <= GPFM_PIN_TWO_RST;
			mask_q <= GPFM_MASK_RST;
			dio_out_q <= GPFM_DIO_OUT_RST;
		end else if (wr_commit && lane0) begin
			if (idx == GPFM_IDX_PIN_ONE) begin
				pin_one_q <= avs_writedata_in[7:0];
			end else if (idx == GPFM_IDX_PIN_TWO) begin
				pin_two_q <= avs_writedata_in[7:0];
			end else if (idx == GPFM_IDX_IRQ_MASK) begin
				mask_q <= avs_writedata_in[2:0];
			end else if (idx == GPFM_IDX_DIRECT_IO) begin
				dio_out_q <= avs_writedata_in[GPFM_DIO_OUT_BIT];
			end
		end
	end

	assign pin_two_function_select_out = pin_two_q[GPFM_SEL_MSB:0];
	assign pin_two_pullup_enable_out = pin_two_q[GPFM_PUP_BIT];
	assign pin_two_drive_strength_out = pin_two_q[GPFM_DRV_MSB:GPFM_DRV_LSB];
	assign pin_one_drive_strength_out = pin_one_q[GPFM_DRV_MSB:GPFM_DRV_LSB];

	// =====================================================
	// input edges and events
	logic prev_q;
	logic prev_ok_q;
	logic rise;
	logic fall;

	// no edge is seen until one sample has been taken after reset
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			prev_q <= 1'b0;
			prev_ok_q <= 1'b0;
		end else begin
			prev_q <= general_pin_one_in;
			prev_ok_q <= 1'b1;
		end
	end

	assign rise = prev_ok_q & ~prev_q & general_pin_one_in;
	assign fall = prev_ok_q & prev_q & ~general_pin_one_in;

	always_comb begin
		events = 3'h0;
		case (sel)
			GPFM_FN_XFALL: events[GPFM_ST_EXT] = fall;
			GPFM_FN_XRISE: events[GPFM_ST_EXT] = rise;
			GPFM_FN_XCHG: events[GPFM_ST_EXT] = rise | fall;
			GPFM_FN_RETX: events[GPFM_ST_RETX] = rise;
			default: events = 3'h0;
		endcase
		// software is warned when a test code is written
		events[GPFM_ST_RSVD] = wr_commit && lane0 && idx == GPFM_IDX_PIN_ONE
			&& gpfm_is_rsvd(avs_writedata_in[4:0]);
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			status_q <= 3'h0;
		end else if (wr_commit && lane0 && idx == GPFM_IDX_IRQ_STATUS) begin
			status_q <= (status_q & ~avs_writedata_in[2:0]) | events;
		end else begin
			status_q <= status_q | events;
		end
	end

	assign irq_out = |(status_q & mask_q);

	// =====================================================
	// output mux
	logic pin_d;
	logic pin_q;
	logic oe_q;
	logic pullup_q;
	logic adc_q;
	logic vref_q;
	logic txd_q;
	logic retx_q;

	always_comb begin
		pin_d = 1'b0;
		case (sel)
			GPFM_FN_NPOR: pin_d = ~por_active_in;
			GPFM_FN_WUT: pin_d = wake_up_timer_expired_in;
			GPFM_FN_LOWBAT: pin_d = low_battery_in;
			GPFM_FN_DOUT: pin_d = dio_out_q;
			GPFM_FN_BITCLK: pin_d = bit_clock_in;
			GPFM_FN_RXDATA: pin_d = rx_data_in;
			GPFM_FN_TXSTATE: pin_d = tx_state_in;
			GPFM_FN_RXSTATE: pin_d = rx_state_in;
			GPFM_FN_TXAFULL: pin_d = tx_almost_full_in;
			GPFM_FN_RXAFULL: pin_d = rx_almost_full_in;
			GPFM_FN_ANT1: pin_d = antenna_one_in;
			GPFM_FN_ANT2: pin_d = antenna_two_in;
			GPFM_FN_PRE_OK: pin_d = preamble_valid_in;
			GPFM_FN_PRE_BAD: pin_d = preamble_invalid_in;
			GPFM_FN_SYNC: pin_d = sync_detected_in;
			GPFM_FN_CCA: pin_d = clear_channel_in;
			GPFM_FN_VDD: pin_d = 1'b1;
			default: pin_d = 1'b0;
		endcase
	end

	// one register stage keeps the pad free of decode glitches
	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			pin_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			pin_q <= gpfm_drives(sel) & pin_d;
			oe_q <= gpfm_drives(sel);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			pullup_q <= 1'b0;
		end else begin
			pullup_q <= pin_one_q[GPFM_PUP_BIT] & gpfm_is_din(sel);
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			adc_q <= 1'b0;
			vref_q <= 1'b0;
			txd_q <= 1'b0;
			retx_q <= 1'b0;
		end else begin
			adc_q <= sel == GPFM_FN_ADC;
			vref_q <= sel == GPFM_FN_VREF;
			txd_q <= sel == GPFM_FN_TXDATA && general_pin_one_in;
			retx_q <= sel == GPFM_FN_RETX && general_pin_one_in;
		end
	end

	assign general_pin_one_out = pin_q;
	assign general_pin_one_oe_out = oe_q;
	assign pin_one_pullup_out = pullup_q;
	assign adc_route_out = adc_q;
	assign vref_route_out = vref_q;
	assign tx_data_out = txd_q;
	assign retransmit_request_out = retx_q;

	// =====================================================
	// checks
	sequence s_cfg_write;
		wr_commit && lane0 && idx == GPFM_IDX_PIN_ONE;
	endsequence

	sequence s_fall_seen;
		sel == GPFM_FN_XFALL && fall;
	endsequence

	sequence s_rise_retx;
		sel == GPFM_FN_RETX && rise;
	endsequence

	AST_PULLUP_ON: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		pin_one_q[GPFM_PUP_BIT] && sel == GPFM_FN_DIN |=> pin_one_pullup_out)
		else $error("pull-up missing on digital input");

	AST_PULLUP_OFF: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		!gpfm_is_din(sel) |=> !pin_one_pullup_out)
		else $error("pull-up on while pin not an input");

	AST_SEL_WRITE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		s_cfg_write |=> sel == $past(avs_writedata_in[4:0]))
		else $error("selector not loaded from bus");

	AST_DRV_WRITE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		s_cfg_write |=> pin_one_drive_strength_out == $past(avs_writedata_in[7:6]))
		else $error("drive strength not loaded from bus");

	AST_NPOR: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		sel == GPFM_FN_NPOR |=> general_pin_one_oe_out
			&& general_pin_one_out == !$past(por_active_in))
		else $error("inverted reset not on pin");

	AST_WUT: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		sel == GPFM_FN_WUT |=> general_pin_one_out == $past(wake_up_timer_expired_in))
		else $error("wake-up flag not on pin");

	AST_LOWBAT: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		sel == GPFM_FN_LOWBAT |=> general_pin_one_out == $past(low_battery_in))
		else $error("low battery flag not on pin");

	AST_DIN_RELEASE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		sel == GPFM_FN_DIN [*2] |-> !general_pin_one_oe_out)
		else $error("pin driven while direct input");

	AST_DOUT: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		sel == GPFM_FN_DOUT |=> general_pin_one_oe_out && general_pin_one_out == $past(dio_out_q))
		else $error("direct output wrong");

	AST_FALL_IRQ: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		s_fall_seen |=> status_q[GPFM_ST_EXT])
		else $error("falling edge not latched");

	AST_ADC: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		sel == GPFM_FN_ADC |=> adc_route_out && !general_pin_one_oe_out)
		else $error("adc route wrong");

	AST_RSVD: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		s_cfg_write && gpfm_is_rsvd(avs_writedata_in[4:0]) |=> status_q[GPFM_ST_RSVD])
		else $error("test code write not flagged");

	AST_RETX: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		s_rise_retx |=> retransmit_request_out && status_q[GPFM_ST_RETX])
		else $error("retransmission request lost");

	AST_VDD: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		sel == GPFM_FN_VDD |=> general_pin_one_out && general_pin_one_oe_out)
		else $error("constant high missing");

	AST_GND: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		sel > GPFM_FN_VDD |=> !general_pin_one_out && general_pin_one_oe_out)
		else $error("constant low missing");

	AST_IRQ_LEVEL: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		|(status_q & mask_q) |-> irq_out)
		else $error("interrupt not raised");

	AST_BUS_ONE_WAIT: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		req && !ack_q |-> avs_waitrequest_out ##1 (!req || !avs_waitrequest_out))
		else $error("bus answer not after one wait cycle");

endmodule

// ---- tb/gpfm_pin_partner.sv ----
// gpfm_pin_partner: board circuitry on general pin one, resolves the pad level
// assumes the bench tells it when to drive and which level to drive
module gpfm_pin_partner (
	input wire logic clk_in,
	input wire logic pin_out_in,
	input wire logic oe_in,
	input wire logic pullup_in,
	input wire logic drive_en_in,
	input wire logic drive_val_in,
	output logic pad_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// =====================================================
	// pad resolution
	// a floating pad toggles every cycle so a missing pull-up cannot pass by luck
	logic float_q = 1'b0;
	always @(posedge clk_in) begin
		float_q <= ~float_q;
	end
	always_comb begin
		if (oe_in)
			pad_out = pin_out_in;
		else if (drive_en_in)
			pad_out = drive_val_in;
		else if (pullup_in)
			pad_out = 1'b1;
		else
			pad_out = float_q;
	end
endmodule

// ---- tb/gpfm_pin_mux_bench.sv ----
// gpfm_pin_mux_bench: register and pin tests of the pin function mux
// assumes a 50 MHz clock and the partner model on the pad
module gpfm_pin_mux_bench;
	import gpfm_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, pen = 1'b0, pval = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic [3:0] be = 4'hF;
	logic wait_o, irq, pin_o, oe, pup, adc, vref, txd, retx, pad, pin_two_pullup_enable;
	logic [1:0] drv, drv2;
	logic [4:0] sel2;
	logic [14:0] src = 15'h0;
	logic [4:0] out_codes [15] = '{GPFM_FN_NPOR, GPFM_FN_WUT, GPFM_FN_LOWBAT, GPFM_FN_BITCLK,
		GPFM_FN_RXDATA, GPFM_FN_TXSTATE, GPFM_FN_RXSTATE, GPFM_FN_TXAFULL, GPFM_FN_RXAFULL,
		GPFM_FN_ANT1, GPFM_FN_ANT2, GPFM_FN_PRE_OK, GPFM_FN_PRE_BAD, GPFM_FN_SYNC, GPFM_FN_CCA};
	logic [2:0] efall = 3'b101, erise = 3'b110;
	int err_total = 0, n_compared = 0, cycles = 0;
	always #10 clk = ~clk;
	gpfm_pin_mux dut (.sys_clk_in(clk), .sys_rst_in(rst), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
		.avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o),
		.irq_out(irq), .por_active_in(src[0]), .wake_up_timer_expired_in(src[1]),
		.low_battery_in(src[2]), .bit_clock_in(src[3]), .rx_data_in(src[4]),
		.tx_state_in(src[5]), .rx_state_in(src[6]), .tx_almost_full_in(src[7]),
		.rx_almost_full_in(src[8]), .antenna_one_in(src[9]), .antenna_two_in(src[10]),
		.preamble_valid_in(src[11]), .preamble_invalid_in(src[12]),
		.sync_detected_in(src[13]), .clear_channel_in(src[14]), .general_pin_one_in(pad),
		.general_pin_one_out(pin_o), .general_pin_one_oe_out(oe), .pin_one_pullup_out(pup),
		.pin_one_drive_strength_out(drv), .adc_route_out(adc), .vref_route_out(vref),
		.tx_data_out(txd), .retransmit_request_out(retx),
		.pin_two_function_select_out(sel2), .pin_two_pullup_enable_out(pin_two_pullup_enable),
		.pin_two_drive_strength_out(drv2));
	gpfm_pin_partner partner (.clk_in(clk), .pin_out_in(pin_o), .oe_in(oe), .pullup_in(pup),
		.drive_en_in(pen), .drive_val_in(pval), .pad_out(pad));
	// =====================================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		input logic [3:0] b);
		@(posedge clk);
		addr <= a;
		wdata <= {24'h0, d};
		be <= b;
		wr <= w;
		rd <= ~w;
		@(posedge clk iff !wait_o);
		rv = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic wreg(input logic [5:0] idx, input logic [7:0] d);
		bus(1'b1, {idx, 2'b00}, d, 4'hF);
	endtask
	task automatic rreg(input logic [5:0] idx);
		bus(1'b0, {idx, 2'b00}, 8'h00, 4'hF);
	endtask
	task automatic settle();
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic drive_pad(input logic v);
		@(posedge clk);
		pval <= v;
	endtask
	// =====================================================
	// timeout, generous against roughly 450 cycles of tests
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			summarize();
		end
	end
	// =====================================================
	// test sequence
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		settle();
		check(32'({oe, pin_o, irq}), 32'h6);
		rreg(GPFM_IDX_PIN_ONE);
		check(rv, 32'h0);
		rreg(GPFM_IDX_IRQ_MASK);
		check(rv, 32'h0);
		// output codes, the 15 sources with pull-up requested so it must stay off, then codes 29 to 31 without it
		for (int i = 0; i < 15; i++) begin
			wreg(GPFM_IDX_PIN_ONE, {2'(i), 1'b1, out_codes[i]});
			@(posedge clk);
			src <= 15'h1 << i;
			settle();
			check(32'({oe, pup, drv, pin_o}), 32'({2'b10, 2'(i), i != 0}));
			@(posedge clk);
			src <= 15'h0;
			settle();
			check(32'(pin_o), 32'(i == 0));
		end
		for (int c = 29; c < 32; c++) begin
			wreg(GPFM_IDX_PIN_ONE, 8'(c));
			settle();
			check(32'({oe, pin_o}), 32'({1'b1, c == 29}));
		end
		// analog routes release the pad
		wreg(GPFM_IDX_PIN_ONE, {3'h0, GPFM_FN_ADC});
		settle();
		check(32'({oe, adc, vref}), 32'h2);
		wreg(GPFM_IDX_PIN_ONE, {3'h0, GPFM_FN_VREF});
		settle();
		check(32'({oe, adc, vref}), 32'h1);
		// reserved test codes
		for (int c = 8; c < 14; c++) begin
			if (c != 10) begin
				wreg(GPFM_IDX_PIN_ONE, 8'(c));
				settle();
				check(32'(oe), 32'h0);
				rreg(GPFM_IDX_IRQ_STATUS);
				check(rv, 32'h1 << GPFM_ST_RSVD);
				wreg(GPFM_IDX_IRQ_STATUS, 8'h07);
			end
		end
		// direct output, then direct input driven and pulled up
		wreg(GPFM_IDX_DIRECT_IO, 8'h01);
		wreg(GPFM_IDX_PIN_ONE, {3'h0, GPFM_FN_DOUT});
		settle();
		check(32'({oe, pin_o}), 32'h3);
		pen <= 1'b1;
		wreg(GPFM_IDX_PIN_ONE, {3'h0, GPFM_FN_DIN});
		settle();
		rreg(GPFM_IDX_DIRECT_IO);
		check(32'({oe, rv[GPFM_DIO_IN_BIT]}), 32'h0);
		pen <= 1'b0;
		wreg(GPFM_IDX_PIN_ONE, {3'h1, GPFM_FN_DIN});
		settle();
		rreg(GPFM_IDX_DIRECT_IO);
		check(32'({pup, rv[GPFM_DIO_IN_BIT]}), 32'h3);
		// external interrupt edges
		pen <= 1'b1;
		pval <= 1'b1;
		wreg(GPFM_IDX_IRQ_MASK, 8'h01);
		for (int j = 0; j < 3; j++) begin
			wreg(GPFM_IDX_PIN_ONE, {3'h0, 5'(GPFM_FN_XFALL + 5'(j))});
			settle();
			wreg(GPFM_IDX_IRQ_STATUS, 8'h07);
			drive_pad(1'b0);
			settle();
			check(32'(irq), 32'(efall[j]));
			wreg(GPFM_IDX_IRQ_STATUS, 8'h01);
			drive_pad(1'b1);
			settle();
			rreg(GPFM_IDX_IRQ_STATUS);
			check(32'({irq, rv[2:0]}), 32'({erise[j], 2'b00, erise[j]}));
		end
		// masked event: status set, interrupt stays low
		wreg(GPFM_IDX_IRQ_MASK, 8'h00);
		wreg(GPFM_IDX_IRQ_STATUS, 8'h07);
		drive_pad(1'b0);
		settle();
		rreg(GPFM_IDX_IRQ_STATUS);
		check(32'({irq, rv[2:0]}), 32'h1);
		wreg(GPFM_IDX_IRQ_STATUS, 8'h07);
		// transmit data and retransmission request inputs
		wreg(GPFM_IDX_PIN_ONE, {3'h0, GPFM_FN_TXDATA});
		drive_pad(1'b1);
		settle();
		check(32'({oe, txd, retx}), 32'h2);
		drive_pad(1'b0);
		wreg(GPFM_IDX_PIN_ONE, {3'h0, GPFM_FN_RETX});
		settle();
		wreg(GPFM_IDX_IRQ_STATUS, 8'h07);
		drive_pad(1'b1);
		settle();
		rreg(GPFM_IDX_IRQ_STATUS);
		check(32'({oe, txd, retx, rv[2:0]}), 32'h0A);
		// pin two fields, masked byte lane and unmapped place
		wreg(GPFM_IDX_PIN_TWO, 8'hA5);
		bus(1'b1, {GPFM_IDX_PIN_TWO, 2'b00}, 8'h3C, 4'hE);
		settle();
		check(32'({drv2, pin_two_pullup_enable, sel2}), 32'hA5);
		rreg(GPFM_IDX_PIN_TWO);
		check(rv, 32'hA5);
		bus(1'b1, 8'hFC, 8'h5A, 4'hF);
		bus(1'b0, 8'hFC, 8'h00, 4'hF);
		check(rv, 32'h0);
		summarize();
	end
endmodule
